// ===== verilog/rsa_defines.svh
// Register offsets, field positions, reset values and timing figures
`ifndef RSA_DEFINES_SVH
`define RSA_DEFINES_SVH
`define RSA_OFS_MAIN_SEL 8'h23
`define RSA_OFS_BACKUP_SEL 8'h24
`define RSA_OFS_SWITCH_SEL 8'h25
`define RSA_RST_MAIN_SEL 8'h37
`define RSA_RST_BACKUP_SEL 8'h00
`define RSA_RST_SWITCH_SEL 8'ha8
`define RSA_BACKUP_WMASK 8'h33
`define RSA_HI_CODE_MSB 7
`define RSA_HI_CODE_LSB 4
`define RSA_LO_CODE_MSB 3
`define RSA_LO_CODE_LSB 0
`define RSA_B18_CODE_MSB 5
`define RSA_B18_CODE_LSB 4
`define RSA_B10_CODE_MSB 1
`define RSA_B10_CODE_LSB 0
`define RSA_CODE_FIRST_MAIN 4'h3
`define RSA_CODE_LAST_MAIN 4'ha
`define RSA_STROBE_FIRST 4'h1
`define RSA_STROBE_FIRST_SEALED 4'h3
`define RSA_STROBE_LAST 4'ha
`define RSA_GAP_SHORT_US 2000
`define RSA_GAP_LONG_US 5000
`define RSA_CLK_MHZ 25
`endif

// ===== verilog/rsa_pkg.sv
// Types shared by the strobe assignment sequencer and its gap timer
package rsa_pkg;
	localparam int RSA_RAILS = 6;
	localparam int RSA_CNT_W = 17;

	// Rail index order on rail_enable and rail_reg_enable
	typedef enum logic [2:0] {
		RSA_BUCK_BOOST = 3'b000,
		RSA_BUCK_THREE = 3'b001,
		RSA_BACKUP_1V0 = 3'b010,
		RSA_BACKUP_1V8 = 3'b011,
		RSA_LV_SWITCH = 3'b100,
		RSA_LINEAR = 3'b101
	} rsa_rail_e_t;

	typedef enum logic [2:0] {
		RSA_IDLE = 3'b000,
		RSA_UP_STROBE = 3'b001,
		RSA_UP_WAIT = 3'b010,
		RSA_DN_STROBE = 3'b011,
		RSA_DN_WAIT = 3'b100
	} rsa_state_t;

	typedef struct packed {
		rsa_state_t state;
		logic [7:0] main_sel;
		logic [7:0] backup_sel;
		logic [7:0] switch_sel;
		logic [3:0] strobe;
		logic [RSA_RAILS-1:0] seq_on;
		logic [RSA_RAILS-1:0] rail_en;
		logic [7:0] rdata;
		logic rd_valid;
		logic busy;
		logic tmr_start;
		logic [RSA_CNT_W-1:0] tmr_count;
	} rsa_core_t;

	typedef struct packed {
		logic active;
		logic done;
		logic [RSA_CNT_W-1:0] left;
	} rsa_timer_t;
endpackage

// ===== verilog/rsa_timer_if.sv
// Handshake between the sequencer and its inter-strobe gap timer
`timescale 1ns/1ps
interface rsa_timer_if;
	import rsa_pkg::*;
	logic start;
	logic [RSA_CNT_W-1:0] count;
	logic done;
	modport ctrl (output start, output count, input done);
	modport tmr (input start, input count, output done);
endinterface

// ===== verilog/rsa_gap_timer.sv
// Gap timer: counts the delay between two consecutive strobes
`timescale 1ns/1ps
module rsa_gap_timer
	import rsa_pkg::*;
(
	input wire logic core_clk,
	input wire logic rst,
	rsa_timer_if.tmr tif
);
	rsa_timer_t cur_reg;
	rsa_timer_t cur_next;

	// Done pulses exactly count cycles after the start pulse, for a count of two or more
	always_comb begin
		cur_next = cur_reg;
		cur_next.done = 1'b0;
		if (tif.start) begin
			cur_next.active = 1'b1;
			cur_next.left = tif.count - 17'h00001;
		end else if (cur_reg.active) begin
			if (cur_reg.left <= 17'h00001) begin
				cur_next.active = 1'b0;
				cur_next.done = 1'b1;
			end else begin
				cur_next.left = cur_reg.left - 17'h00001;
			end
		end
	end

	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			cur_reg <= '0;
		end else begin
			cur_reg <= cur_next;
		end
	end

	assign tif.done = cur_reg.done;
endmodule // rsa_gap_timer

// ===== verilog/rsa_sequencer.sv
// Rail strobe assignment registers and the power-up/power-down strobe sequencer
`timescale 1ns/1ps
`include "rsa_defines.svh"
module rsa_sequencer
	import rsa_pkg::*;
#(
	parameter int GAP_SHORT_CYCLES = `RSA_GAP_SHORT_US * `RSA_CLK_MHZ,
	parameter int GAP_LONG_CYCLES = `RSA_GAP_LONG_US * `RSA_CLK_MHZ
)
(
	input wire logic core_clk,
	input wire logic rst,
	input wire logic reg_wr_en,
	input wire logic reg_rd_en,
	input wire logic [7:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	output logic [7:0] reg_rdata,
	output logic reg_rd_valid,
	input wire logic power_up_req,
	input wire logic power_down_req,
	input wire logic freshness_seal_flag,
	input wire logic [8:0] gap_delay_select,
	input wire logic [RSA_RAILS-1:0] rail_reg_enable,
	output logic [RSA_RAILS-1:0] rail_enable,
	output logic seq_busy,
	output logic [3:0] seq_strobe
);
	rsa_core_t cur_reg;
	rsa_core_t cur_next;
	rsa_timer_if tif ();

	// ----------------------------------------------------------------
	// Code decoding
	// ----------------------------------------------------------------
	// Returns the strobe number a main code names, zero when uncontrolled
	function automatic logic [3:0] main_strobe(input logic [3:0] code);
		if (code >= `RSA_CODE_FIRST_MAIN && code <= `RSA_CODE_LAST_MAIN) begin
			main_strobe = code;
		end else begin
			main_strobe = 4'h0;
		end
	endfunction

	function automatic logic [3:0] backup_strobe(input logic [1:0] code);
		if (code == 2'h1 || code == 2'h2) begin
			backup_strobe = {2'h0, code};
		end else begin
			backup_strobe = 4'h0;
		end
	endfunction

	function automatic logic [3:0] rail_strobe(input rsa_core_t c, input int rail);
		unique case (rail)
			0: rail_strobe = main_strobe(c.main_sel[`RSA_HI_CODE_MSB:`RSA_HI_CODE_LSB]);
			1: rail_strobe = main_strobe(c.main_sel[`RSA_LO_CODE_MSB:`RSA_LO_CODE_LSB]);
			2: rail_strobe = backup_strobe(c.backup_sel[`RSA_B10_CODE_MSB:`RSA_B10_CODE_LSB]);
			3: rail_strobe = backup_strobe(c.backup_sel[`RSA_B18_CODE_MSB:`RSA_B18_CODE_LSB]);
			4: rail_strobe = main_strobe(c.switch_sel[`RSA_HI_CODE_MSB:`RSA_HI_CODE_LSB]);
			default: rail_strobe = main_strobe(c.switch_sel[`RSA_LO_CODE_MSB:`RSA_LO_CODE_LSB]);
		endcase
	endfunction

	function automatic logic [RSA_CNT_W-1:0] gap_cycles(input logic long_sel);
		if (long_sel) begin
			gap_cycles = RSA_CNT_W'(GAP_LONG_CYCLES);
		end else begin
			gap_cycles = RSA_CNT_W'(GAP_SHORT_CYCLES);
		end
	endfunction

	// ----------------------------------------------------------------
	// Next state
	// ----------------------------------------------------------------
	always_comb begin
		logic [3:0] first_strobe;
		logic [3:0] rs;
		first_strobe = freshness_seal_flag ? `RSA_STROBE_FIRST_SEALED : `RSA_STROBE_FIRST;
		rs = 4'h0;
		cur_next = cur_reg;
		cur_next.rd_valid = 1'b0;
		cur_next.tmr_start = 1'b0;

		// Register writes; reserved backup bits are never stored
		if (reg_wr_en) begin
			unique case (reg_addr)
				`RSA_OFS_MAIN_SEL: cur_next.main_sel = reg_wdata;
				`RSA_OFS_BACKUP_SEL: cur_next.backup_sel = reg_wdata & `RSA_BACKUP_WMASK;
				`RSA_OFS_SWITCH_SEL: cur_next.switch_sel = reg_wdata;
				default: ;
			endcase
		end

		// Reads show the stored codes; unmapped addresses read zero
		if (reg_rd_en) begin
			cur_next.rd_valid = 1'b1;
			unique case (reg_addr)
				`RSA_OFS_MAIN_SEL: cur_next.rdata = cur_reg.main_sel;
				`RSA_OFS_BACKUP_SEL: cur_next.rdata = cur_reg.backup_sel;
				`RSA_OFS_SWITCH_SEL: cur_next.rdata = cur_reg.switch_sel;
				default: cur_next.rdata = 8'h00;
			endcase
		end

		unique case (cur_reg.state)
			RSA_IDLE: begin
				if (power_up_req) begin
					cur_next.state = RSA_UP_STROBE;
					cur_next.strobe = first_strobe;
					cur_next.busy = 1'b1;
				end else if (power_down_req) begin
					cur_next.state = RSA_DN_STROBE;
					cur_next.strobe = `RSA_STROBE_LAST;
					cur_next.busy = 1'b1;
				end
			end
			RSA_UP_STROBE: begin
				// Every rail naming this strobe turns on in the same cycle
				for (int i = 0; i < RSA_RAILS; i++) begin
					rs = rail_strobe(cur_reg, i);
					if (rs != 4'h0 && rs == cur_reg.strobe) begin
						cur_next.seq_on[i] = 1'b1;
					end
				end
				if (cur_reg.strobe == `RSA_STROBE_LAST) begin
					cur_next.state = RSA_IDLE;
					cur_next.busy = 1'b0;
				end else begin
					cur_next.state = RSA_UP_WAIT;
					cur_next.tmr_start = 1'b1;
					cur_next.tmr_count = gap_cycles(gap_delay_select[cur_reg.strobe - 4'h1]);
				end
			end
			RSA_UP_WAIT: begin
				if (tif.done) begin
					cur_next.state = RSA_UP_STROBE;
					cur_next.strobe = cur_reg.strobe + 4'h1;
				end
			end
			RSA_DN_STROBE: begin
				for (int i = 0; i < RSA_RAILS; i++) begin
					rs = rail_strobe(cur_reg, i);
					if (rs != 4'h0 && rs == cur_reg.strobe) begin
						// Backup domain stays up once the seal is broken
						if (!(freshness_seal_flag && (i == 2 || i == 3))) begin
							cur_next.seq_on[i] = 1'b0;
						end
					end
				end
				if (cur_reg.strobe <= first_strobe) begin
					cur_next.state = RSA_IDLE;
					cur_next.busy = 1'b0;
				end else begin
					cur_next.state = RSA_DN_WAIT;
					cur_next.tmr_start = 1'b1;
					cur_next.tmr_count = gap_cycles(gap_delay_select[cur_reg.strobe - 4'h2]);
				end
			end
			RSA_DN_WAIT: begin
				if (tif.done) begin
					cur_next.state = RSA_DN_STROBE;
					cur_next.strobe = cur_reg.strobe - 4'h1;
				end
			end
			default: begin
				cur_next.state = RSA_IDLE;
				cur_next.busy = 1'b0;
			end
		endcase

		// Uncontrolled rails follow their register enable
		for (int i = 0; i < RSA_RAILS; i++) begin
			if (rail_strobe(cur_next, i) == 4'h0) begin
				cur_next.rail_en[i] = rail_reg_enable[i];
			end else begin
				cur_next.rail_en[i] = cur_next.seq_on[i];
			end
		end
	end

	// ----------------------------------------------------------------
	// State register
	// ----------------------------------------------------------------
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			cur_reg <= '0;
			cur_reg.state <= RSA_IDLE;
			cur_reg.main_sel <= `RSA_RST_MAIN_SEL;
			cur_reg.backup_sel <= `RSA_RST_BACKUP_SEL;
			cur_reg.switch_sel <= `RSA_RST_SWITCH_SEL;
		end else begin
			cur_reg <= cur_next;
		end
	end

	assign tif.start = cur_reg.tmr_start;
	assign tif.count = cur_reg.tmr_count;

	rsa_gap_timer u_gap_timer (
		.core_clk(core_clk),
		.rst(rst),
		.tif(tif.tmr)
	);

	assign reg_rdata = cur_reg.rdata;
	assign reg_rd_valid = cur_reg.rd_valid;
	assign rail_enable = cur_reg.rail_en;
	assign seq_busy = cur_reg.busy;
	assign seq_strobe = cur_reg.strobe;
endmodule // rsa_sequencer

// ===== tb/rsa_sequencer_sva.sv
// Port checks for the rail strobe assignment sequencer
`timescale 1ns/1ps
module rsa_sequencer_sva
	import rsa_pkg::*;
#(
	parameter int GAP_SHORT_CYCLES = 4,
	parameter int GAP_LONG_CYCLES = 7
)
(
	input wire logic core_clk,
	input wire logic rst,
	input wire logic reg_rd_en,
	input wire logic [7:0] reg_addr,
	input wire logic [7:0] reg_rdata,
	input wire logic reg_rd_valid,
	input wire logic power_up_req,
	input wire logic power_down_req,
	input wire logic freshness_seal_flag,
	input wire logic [RSA_RAILS-1:0] rail_reg_enable,
	input wire logic [RSA_RAILS-1:0] rail_enable,
	input wire logic seq_busy,
	input wire logic [3:0] seq_strobe
);
	default clocking @(posedge core_clk); endclocking
	default disable iff (rst);
	a_read_answer: assert property (reg_rd_en |=> reg_rd_valid)
		else $error("read not answered");
	a_valid_cause: assert property (reg_rd_valid |-> $past(reg_rd_en))
		else $error("read valid without read");
	a_backup_reserved: assert property ($past(reg_rd_en) && $past(reg_addr) == 8'h24
		|-> (reg_rdata & 8'hcc) == 8'h00) else $error("reserved bits not zero");
	a_unmapped_zero: assert property ($past(reg_rd_en)
		&& !($past(reg_addr) inside {8'h23, 8'h24, 8'h25}) |-> reg_rdata == 8'h00)
		else $error("unmapped read not zero");
	a_up_first: assert property ($rose(seq_busy) && $past(power_up_req)
		|-> seq_strobe == ($past(freshness_seal_flag) ? 4'h3 : 4'h1))
		else $error("wrong first strobe");
	a_down_first: assert property ($rose(seq_busy) && !$past(power_up_req)
		|-> seq_strobe == 4'ha) else $error("power-down not from strobe ten");
	a_step_one: assert property (seq_busy && $past(seq_busy) && $changed(seq_strobe)
		|-> seq_strobe == $past(seq_strobe) + 4'h1 || seq_strobe + 4'h1 == $past(seq_strobe))
		else $error("strobe skipped");
	// Fixed floor matches the shortened gap used in simulation
	a_gap_hold: assert property ($changed(seq_strobe) && seq_busy
		|=> $stable(seq_strobe) [*3]) else $error("gap too short");
	a_req_start: assert property (!seq_busy && (power_up_req || power_down_req)
		|=> seq_busy) else $error("request not taken");
	a_backup_kept: assert property (freshness_seal_flag && $past(freshness_seal_flag)
		&& (seq_busy || $past(seq_busy)) && $past(rail_reg_enable, 1) == $past(rail_reg_enable, 2)
		|-> !$fell(rail_enable[2]) && !$fell(rail_enable[3])) else $error("backup rail dropped");
endmodule // rsa_sequencer_sva
bind rsa_sequencer rsa_sequencer_sva #(.GAP_SHORT_CYCLES(GAP_SHORT_CYCLES),
	.GAP_LONG_CYCLES(GAP_LONG_CYCLES)) chk_u (.core_clk(core_clk), .rst(rst),
	.reg_rd_en(reg_rd_en), .reg_addr(reg_addr), .reg_rdata(reg_rdata),
	.reg_rd_valid(reg_rd_valid), .power_up_req(power_up_req),
	.power_down_req(power_down_req), .freshness_seal_flag(freshness_seal_flag),
	.rail_reg_enable(rail_reg_enable), .rail_enable(rail_enable),
	.seq_busy(seq_busy), .seq_strobe(seq_strobe));

// ===== tb/rsa_rail_model.sv
// Rail model: notes the strobe at which each converter was switched on
`timescale 1ns/1ps
module rsa_rail_model
	import rsa_pkg::*;
(
	input wire logic core_clk,
	input wire logic rst,
	input wire logic [RSA_RAILS-1:0] rail_enable,
	input wire logic [3:0] seq_strobe,
	output logic [RSA_RAILS-1:0][3:0] on_at
);
	logic [RSA_RAILS-1:0] prev_reg;
	always @(posedge core_clk or posedge rst) begin
		if (rst) begin
			prev_reg <= '0;
			on_at <= '0;
		end else begin
			prev_reg <= rail_enable;
			for (int i = 0; i < RSA_RAILS; i++)
				if (rail_enable[i] && !prev_reg[i])
					on_at[i] <= seq_strobe;
		end
	end
endmodule // rsa_rail_model

// ===== tb/rail_strobe_assignment_bench.sv
// Self-checking bench for the rail strobe assignment sequencer
`timescale 1ns/1ps
module rail_strobe_assignment_bench;
	import rsa_pkg::*;
	typedef struct {logic [7:0] a; logic [7:0] w; logic [7:0] r;} rsa_row_t;
	typedef struct {logic s; logic up; logic [5:0] r;} rsa_run_t;
	logic core_clk = 0, rst = 1, reg_wr_en = 0, reg_rd_en = 0, reg_rd_valid, seq_busy;
	logic power_up_req = 0, power_down_req = 0, freshness_seal_flag = 0;
	logic [7:0] reg_addr = 8'h00, reg_wdata = 8'h00, reg_rdata, d;
	logic [8:0] gap_delay_select = 9'h0aa;
	logic [5:0] rail_reg_enable = 6'h20, rail_enable;
	logic [3:0] seq_strobe;
	logic [RSA_RAILS-1:0][3:0] on_at;
	localparam int GAP_S = 4;
	localparam int GAP_L = 7;
	int mismatches = 0, checked = 0;
	rsa_row_t rows [6] = '{'{8'h23, 8'h5c, 8'h5c}, '{8'h24, 8'hff, 8'h33},
		'{8'h25, 8'h0f, 8'h0f}, '{8'h2a, 8'hff, 8'h00}, '{8'h24, 8'hcc, 8'h00},
		'{8'h23, 8'ha3, 8'ha3}};
	// Seal, direction and rail levels expected once the run settles
	rsa_run_t runs [5] = '{'{0, 1, 6'h3f}, '{1, 0, 6'h2c}, '{1, 1, 6'h3f},
		'{0, 0, 6'h20}, '{1, 1, 6'h33}};
	rsa_sequencer #(.GAP_SHORT_CYCLES(GAP_S), .GAP_LONG_CYCLES(GAP_L)) dut_u (.core_clk(core_clk),
		.rst(rst), .reg_wr_en(reg_wr_en), .reg_rd_en(reg_rd_en), .reg_addr(reg_addr),
		.reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .reg_rd_valid(reg_rd_valid),
		.power_up_req(power_up_req), .power_down_req(power_down_req),
		.freshness_seal_flag(freshness_seal_flag), .gap_delay_select(gap_delay_select),
		.rail_reg_enable(rail_reg_enable), .rail_enable(rail_enable), .seq_busy(seq_busy),
		.seq_strobe(seq_strobe));
	rsa_rail_model model_u (.core_clk(core_clk), .rst(rst), .rail_enable(rail_enable),
		.seq_strobe(seq_strobe), .on_at(on_at));
	initial begin
		forever #20 core_clk = ~core_clk;
	end
	task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
		checked++;
		if (g !== e) begin
			mismatches++;
			$display("wrong value %s expected %h seen %h", n, e, g);
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [7:0] w);
		@(posedge core_clk);
		#1 reg_wr_en = 1;
		reg_addr = a;
		reg_wdata = w;
		@(posedge core_clk);
		#1 reg_wr_en = 0;
	endtask
	task automatic rd(input logic [7:0] a, output logic [7:0] r);
		@(posedge core_clk);
		#1 reg_rd_en = 1;
		reg_addr = a;
		@(posedge core_clk);
		#1 reg_rd_en = 0;
		r = reg_rdata;
		chk("read valid", 8'h01, {7'h00, reg_rd_valid});
	endtask
	task automatic run(input logic up);
		int n;
		int e;
		@(posedge core_clk);
		#1 power_up_req = up;
		power_down_req = !up;
		@(posedge core_clk);
		#1 power_up_req = 0;
		power_down_req = 0;
		n = 0;
		// One cycle to leave the last strobe, each gap its count plus two of overhead
		e = 1;
		for (int g = freshness_seal_flag ? 2 : 0; g < 9; g++)
			e += (gap_delay_select[g] ? GAP_L : GAP_S) + 2;
		while (n < 200 && seq_busy !== 1'b0) begin
			@(posedge core_clk);
			#1 n++;
		end
		chk("run cycles", e[7:0], n[7:0]);
		chk("last strobe", up ? 8'h0a : (freshness_seal_flag ? 8'h03 : 8'h01),
			{4'h0, seq_strobe});
		repeat (2) @(posedge core_clk);
		#1;
	endtask
	task automatic summarize;
		$display("comparisons %0d mismatches %0d", checked, mismatches);
		if (mismatches == 0 && checked > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask
	initial begin
		repeat (10000) @(posedge core_clk);
		mismatches++;
		summarize;
	end
	initial begin
		repeat (16) @(posedge core_clk);
		#1 rst = 0;
		foreach (rows[i]) begin
			wr(rows[i].a, rows[i].w);
			rd(rows[i].a, d);
			chk("register", rows[i].r, d);
		end
		rst = 1;
		repeat (16) @(posedge core_clk);
		#1 rst = 0;
		rd(8'h23, d);
		chk("main reset", 8'h37, d);
		rd(8'h24, d);
		chk("backup reset", 8'h00, d);
		rd(8'h25, d);
		chk("switch reset", 8'ha8, d);
		wr(8'h24, 8'h21);
		wr(8'h25, 8'h3b);
		for (int c = 0; c < 16; c++) begin
			wr(8'h23, {c[3:0], 4'h0});
			run(1);
			chk("buck-boost on", {7'h00, c >= 3 && c <= 10}, {7'h00, rail_enable[0]});
			if (c >= 3 && c <= 10)
				chk("buck-boost strobe", c[7:0], {4'h0, on_at[0]});
			run(0);
		end
		wr(8'h23, 8'h4a);
		foreach (runs[i]) begin
			freshness_seal_flag = runs[i].s;
			run(runs[i].up);
			chk("rails", {2'b00, runs[i].r}, {2'b00, rail_enable});
			if (i == 0) begin
				chk("bb strobe", 8'h04, {4'h0, on_at[0]});
				chk("buck3 strobe", 8'h0a, {4'h0, on_at[1]});
				chk("1v0 strobe", 8'h01, {4'h0, on_at[2]});
				chk("1v8 strobe", 8'h02, {4'h0, on_at[3]});
				chk("switch strobe", 8'h03, {4'h0, on_at[4]});
			end
		end
		// Code 3h on both backup fields hands them back to their register enables
		freshness_seal_flag = 0;
		rail_reg_enable = 6'h28;
		wr(8'h24, 8'h33);
		run(1);
		chk("uncontrolled backup", 8'h3b, {2'b00, rail_enable});
		summarize;
	end
endmodule // rail_strobe_assignment_bench
